// ==== design/grt_pkg.sv ====
// Purpose: shared constants and types for the gated reload timer
// Assumes: single 100 MHz clock, synchronous active-high reset
// Notes: prescale select is a power of two from 1 to 128
package grt_pkg;

  // ---------------------------------------------------------------
  // Modes and widths
  // ---------------------------------------------------------------
  localparam int GRT_CNT_W = 16;
  localparam int GRT_PRE_W = 3;
  localparam int GRT_DIV_W = 7;
  localparam logic [15:0] GRT_RESTART = 16'h0001;
  localparam logic [15:0] GRT_CNT_RST = 16'h0000;
  localparam logic [15:0] GRT_RLD_RST = 16'hFFFF;
  localparam logic [6:0] GRT_DIV_RST = 7'h00;

  typedef enum logic [1:0] {
    GRT_MODE_CONT = 2'h0,
    GRT_MODE_COUNTER = 2'h1,
    GRT_MODE_GATED = 2'h2,
    GRT_MODE_CAPCMP = 2'h3
  } grt_mode_t;

  // Run states, one-hot
  typedef enum logic [2:0] {
    GRT_ST_OFF = 3'b001,
    GRT_ST_ARM = 3'b010,
    GRT_ST_RUN = 3'b100
  } grt_state_t;

  // Static configuration carried as one group
  typedef struct packed {
    logic enable;
    grt_mode_t mode;
    logic [GRT_PRE_W-1:0] prescale;
    logic polarity;
    logic out_init;
    logic out_af_en;
  } grt_cfg_t;

endpackage

// ==== design/grt_prescaler.sv ====
// Purpose: power-of-two prescaler giving a one-cycle tick
// Assumes: clr held while the timer is off
// Notes: select 0 ticks every cycle
`timescale 1ns/1ps
module grt_prescaler
  import grt_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic srst_i, // Sync reset
  input wire logic clr_i, // Clear divider
  input wire logic [GRT_PRE_W-1:0] sel_i, // Divide by 2**sel
  output logic tick_o // One-cycle enable
);

  logic [GRT_DIV_W-1:0] div_reg;
  logic [GRT_DIV_W-1:0] div_next;
  logic [GRT_DIV_W-1:0] mask;

  // Tick when the low sel bits are all ones
  always_comb begin
    mask = GRT_DIV_W'((8'h01 << sel_i) - 8'h01);
    tick_o = ((div_reg & mask) == mask) && !clr_i; // [R18]
    div_next = clr_i ? GRT_DIV_RST : div_reg + 7'h01; // [R18]
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_reg <= GRT_DIV_RST;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule

// ==== design/grt_timer.sv ====
// Purpose: 16-bit reload timer with continuous, counter, gated, capture
// Assumes: timer input arrives asynchronously from a GPIO pin
// Notes: count loaded by strobe while the timer is off, reload loaded by strobe at any time
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Continuous: start count used first pass only, later reloads give 0001H.
// (R2) Continuous always counts the prescaled system clock.
// (R3) First continuous time-out counts from start value to reload.
// (R4) Software disables, configures, loads, then enables last.
// (R5) Counter mode counts input edges chosen by polarity select.
// (R6) Counter mode bypasses the prescaler, one per edge.
// (R7) External input stays at or below quarter system clock.
// (R8) Counter mode at reload: interrupt, back to 0001H, keep counting.
// (R9) Gated mode counts only while input at active level.
// (R10) Gated mode interrupts on input deassertion and on reload.
// (R11) Gated mode counts clock to reload, interrupts, restarts 0001H.
// (R12) Gated mode start count only first pass, then 0001H.
// (R13) Output pin toggles at each reset when output function enabled.
// (R14) Software compares input level with polarity to find cause.
// (R15) Software enables timer before asserting gated input.
// (R16) Capture/compare waits for first chosen edge then counts clock.
// (R17) Compare time is compare minus start, times prescale.
// (R18) Prescaler divides clock in timed modes, cleared when disabled.
// (R19) Output holds initial level while disabled, toggles from it.
module grt_timer
  import grt_pkg::*;
(
  input wire logic clk_i, // System clock 100 MHz
  input wire logic srst_i, // Sync reset, active high
  input wire grt_cfg_t cfg_i, // Mode, prescale, polarity, enable
  input wire logic cnt_wr_i, // Load count strobe
  input wire logic [15:0] cnt_wdata_i, // Count value to load
  input wire logic rld_wr_i, // Load reload strobe
  input wire logic [15:0] rld_wdata_i, // Reload value to load
  input wire logic [15:0] cmp_i, // Compare value
  input wire logic tin_i, // Timer input pin, async
  output logic [15:0] count_o, // Current count
  output logic irq_o, // One-cycle interrupt pulse
  output logic cmp_hit_o, // One-cycle compare event
  output logic tout_o, // Timer output pin level
  output logic tin_level_o // Synchronised input level
);

  // ---------------------------------------------------------------
  // Input synchroniser and edge detection
  // ---------------------------------------------------------------
  logic sync1_reg, sync2_reg, last_reg;
  logic sync1_next, sync2_next, last_next;
  logic active, edge_act, edge_deact;

  // Second stage and later only feed logic; first stage is isolated
  always_comb begin
    sync1_next = tin_i;
    sync2_next = sync1_reg;
    last_next = sync2_reg;
    active = sync2_reg ^ ~cfg_i.polarity;
    edge_act = active && !(last_reg ^ ~cfg_i.polarity);
    edge_deact = !active && (last_reg ^ ~cfg_i.polarity);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg <= last_next;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic tick;

  grt_prescaler u_pre (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .clr_i(!cfg_i.enable),
    .sel_i(cfg_i.prescale),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // Counter core
  // ---------------------------------------------------------------
  grt_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next, rld_reg, rld_next;
  logic irq_reg, irq_next, hit_reg, hit_next;
  logic tout_reg, tout_next, lvl_reg;
  logic step;
  logic reach;

  // Pick the increment source per mode and handle reload
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rld_next = rld_wr_i ? rld_wdata_i : rld_reg;
    irq_next = 1'b0;
    hit_next = 1'b0;
    tout_next = tout_reg;
    step = 1'b0;
    unique case (cfg_i.mode)
      GRT_MODE_CONT: step = tick; // [R2] [R18]
      GRT_MODE_COUNTER: step = edge_act; // [R5] [R6]
      GRT_MODE_GATED: step = tick && active; // [R9] [R11] [R18]
      GRT_MODE_CAPCMP: step = tick; // [R16] [R18]
    endcase
    reach = (cnt_reg == rld_reg);
    unique case (state_reg)
      GRT_ST_OFF: begin
        // Output parked at its initial level until enabled
        tout_next = cfg_i.out_init; // [R19]
        if (cnt_wr_i) begin
          cnt_next = cnt_wdata_i;
        end
        if (cfg_i.enable) begin
          state_next = (cfg_i.mode == GRT_MODE_CAPCMP) ? GRT_ST_ARM
                                                       : GRT_ST_RUN;
        end
      end
      GRT_ST_ARM: begin
        // Hold off until the first chosen edge
        if (!cfg_i.enable) begin
          state_next = GRT_ST_OFF;
          tout_next = cfg_i.out_init; // [R19]
        end else if (edge_act) begin
          state_next = GRT_ST_RUN; // [R16]
        end
      end
      GRT_ST_RUN: begin
        if (!cfg_i.enable) begin
          // Park the pin at once, not one cycle late in OFF
          state_next = GRT_ST_OFF;
          tout_next = cfg_i.out_init; // [R19]
        end else begin
          if (cfg_i.mode == GRT_MODE_GATED && edge_deact) begin
            irq_next = 1'b1; // [R10]
          end
          if (step) begin
            if (reach && cfg_i.mode != GRT_MODE_CAPCMP) begin
              // Restart at one, not the loaded start value
              cnt_next = GRT_RESTART; // [R1] [R3] [R8] [R11] [R12]
              irq_next = 1'b1; // [R8] [R10] [R11]
              if (cfg_i.out_af_en) begin
                tout_next = !tout_reg; // [R13]
              end
            end else begin
              cnt_next = cnt_reg + 16'h0001;
            end
            // Compare event after (cmp - start) prescaled ticks
            if (cfg_i.mode == GRT_MODE_CAPCMP
                && cnt_reg + 16'h0001 == cmp_i) begin
              hit_next = 1'b1; // [R17]
              irq_next = 1'b1;
              if (cfg_i.out_af_en) begin
                tout_next = !tout_reg; // [R13]
              end
            end
          end
        end
      end
      default: state_next = GRT_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= GRT_ST_OFF;
      cnt_reg <= GRT_CNT_RST;
      rld_reg <= GRT_RLD_RST;
      irq_reg <= 1'b0;
      hit_reg <= 1'b0;
      tout_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
      irq_reg <= irq_next;
      hit_reg <= hit_next;
      tout_reg <= tout_next;
      lvl_reg <= sync2_reg;
    end
  end

  // Outputs straight from flops
  assign count_o = cnt_reg;
  assign irq_o = irq_reg;
  assign cmp_hit_o = hit_reg;
  assign tout_o = tout_reg;
  assign tin_level_o = lvl_reg; // [R14]

endmodule

// ==== sim/grt_properties.sv ====
// Purpose: port-level timing properties of the reload timer
// Assumes: one clock, synchronous reset
// Notes: reload value shadowed from its write strobe
`timescale 1ns/1ps
module grt_properties
  import grt_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic srst_i, // Reset
  input wire grt_cfg_t cfg_i, // Config
  input wire logic cnt_wr_i, // Count load
  input wire logic [15:0] cnt_wdata_i, // Count data
  input wire logic rld_wr_i, // Reload load
  input wire logic [15:0] rld_wdata_i, // Reload data
  input wire logic [15:0] cmp_i, // Compare
  input wire logic [15:0] count_o, // Count
  input wire logic irq_o, // Interrupt
  input wire logic cmp_hit_o, // Compare hit
  input wire logic tout_o, // Output pin
  input wire logic tin_level_o // Input level
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic [15:0] rld_reg;
  logic [15:0] rld_next;
  logic on;
  // Shadow reload, so restarts are judged against the live value
  assign on = cfg_i.enable;
  always_comb rld_next = rld_wr_i ? rld_wdata_i : rld_reg;
  always_ff @(posedge clk_i) rld_reg <= srst_i ? GRT_RLD_RST : rld_next;
  property p_idle_out; !on |=> tout_o == $past(cfg_i.out_init); endproperty
  a_idle_out: assert property (p_idle_out) else $error("tout idle");
  property p_load;
    !on && $past(!on) && cnt_wr_i |=> count_o == $past(cnt_wdata_i);
  endproperty
  a_load: assert property (p_load) else $error("count load");
  property p_hold; !on && $past(!on) && !cnt_wr_i |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_restart;
    on && $past(on) && cfg_i.mode != GRT_MODE_CAPCMP && $changed(count_o)
    && $past(count_o) == rld_reg |-> count_o == GRT_RESTART && irq_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_step; on && $past(on) && $changed(count_o) |->
    count_o == $past(count_o) + 16'h0001 || count_o == GRT_RESTART;
  endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_gate; (on && cfg_i.mode == GRT_MODE_GATED &&
    tin_level_o != cfg_i.polarity) [*4] |-> $stable(count_o);
  endproperty
  a_gate: assert property (p_gate) else $error("gate count");
  property p_hit; cmp_hit_o |-> irq_o && count_o == cmp_i; endproperty
  a_hit: assert property (p_hit) else $error("compare hit");
  property p_toggle;
    on && $past(on) && $changed(tout_o) |-> irq_o && cfg_i.out_af_en;
  endproperty
  a_toggle: assert property (p_toggle) else $error("tout toggle");
  property p_div; on && cfg_i.mode == GRT_MODE_CONT &&
    cfg_i.prescale == 3'h1 && $changed(count_o) |=> $stable(count_o);
  endproperty
  a_div: assert property (p_div) else $error("prescale");
endmodule

// ==== sim/grt_tin_model.sv ====
// Purpose: external source on the timer input pin
// Assumes: moves 1 ns after a rising clock edge
// Notes: pin rests at its last level between bursts
`timescale 1ns/1ps
module grt_tin_model (
  input wire logic clk_i, // System clock
  output logic tin_o // Timer input pin
);
  initial tin_o = 1'b0;
  // Toggle every half cycles; half of 2 or more stays at or below clk/4
  task automatic burst(input int n, input int half);
    repeat (2 * n) begin
      repeat (half) @(posedge clk_i);
      #1 tin_o = !tin_o;
    end
  endtask
  // Move the pin to a level
  task automatic level(input logic v);
    @(posedge clk_i) #1 tin_o = v;
  endtask
endmodule

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the gated reload timer
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected figures come from start, reload and prescale
`timescale 1ns/1ps
module tb;
  import grt_pkg::*;
  logic clk_i = 1'b0, srst_i = 1'b1, cnt_wr_i = 1'b0, rld_wr_i = 1'b0;
  grt_cfg_t cfg_i = '0;
  logic [15:0] cnt_wdata_i = '0, rld_wdata_i = '0, cmp_i = '0, count_o;
  logic tin_i, tout_o, tin_level_o, irq_o, cmp_hit_o;
  int n_mismatch = 0, comparisons = 0, n_irq = 0, n;
  grt_timer dut (.clk_i, .srst_i, .cfg_i, .cnt_wr_i, .cnt_wdata_i, .rld_wr_i,
    .rld_wdata_i, .cmp_i, .tin_i, .count_o, .irq_o, .cmp_hit_o, .tout_o,
    .tin_level_o);
  grt_tin_model pm (.clk_i, .tin_o(tin_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq_o === 1'b1) n_irq++;
  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for the next interrupt; n holds the cycles taken
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge clk_i) #1;
      n++;
    end while (irq_o !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      chk("irq wait", 16'h0001, 16'h0000);
      complete_run();
    end
  endtask
  // Disable, configure, load, then enable last
  task automatic setup(input grt_mode_t m, input logic [2:0] p,
    input logic [15:0] c, r);
    @(posedge clk_i) #1 cfg_i = '{1'b0, m, p, 1'b1, 1'b0, 1'b1};
    @(posedge clk_i) #1 cnt_wr_i = 1'b1;
    cnt_wdata_i = c;
    rld_wr_i = 1'b1;
    rld_wdata_i = r;
    @(posedge clk_i) #1 cnt_wr_i = 1'b0;
    rld_wr_i = 1'b0;
    cfg_i.enable = 1'b1;
    n_irq = 0;
  endtask
  task automatic t_cont();
    setup(GRT_MODE_CONT, 3'h1, 16'h0005, 16'h0008);
    chk("tout idle", 16'h0000, 16'(tout_o));
    wait_irq();
    chk("first pass", 16'h0001, 16'(n < 16));
    chk("restart", GRT_RESTART, count_o);
    chk("tout", 16'h0001, 16'(tout_o));
    wait_irq();
    chk("period", 16'h0010, 16'(n));
    chk("tout", 16'h0000, 16'(tout_o));
  endtask
  // Prescale 7 set on purpose: counter mode must ignore it
  task automatic t_counter();
    setup(GRT_MODE_COUNTER, 3'h7, 16'h0001, 16'h0003);
    pm.burst(5, 4);
    repeat (8) @(posedge clk_i);
    chk("edges", 16'h0003, count_o);
    chk("irqs", 16'h0001, 16'(n_irq));
  endtask
  task automatic t_gated();
    setup(GRT_MODE_GATED, 3'h0, 16'h0001, 16'hFFFF);
    repeat (4) @(posedge clk_i);
    chk("gate idle", 16'h0001, count_o);
    pm.level(1'b1);
    repeat (20) @(posedge clk_i);
    chk("tin level", 16'h0001, 16'(tin_level_o));
    pm.level(1'b0);
    repeat (8) @(posedge clk_i);
    chk("gated", 16'h0016, count_o);
    chk("deassert", 16'h0001, 16'(n_irq));
  endtask
  task automatic t_capcmp();
    cmp_i = 16'h000A;
    setup(GRT_MODE_CAPCMP, 3'h0, 16'h0000, 16'hFFFF);
    repeat (12) @(posedge clk_i);
    chk("armed", 16'h0000, count_o);
    pm.level(1'b1);
    wait_irq();
    chk("compare", 16'h000A, count_o);
    chk("hit", 16'h0001, 16'(cmp_hit_o));
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_cont();
    t_counter();
    t_gated();
    t_capcmp();
    complete_run();
  end
endmodule
bind grt_timer grt_properties u_props (.clk_i, .srst_i, .cfg_i, .cnt_wr_i,
  .cnt_wdata_i, .rld_wr_i, .rld_wdata_i, .cmp_i, .count_o, .irq_o,
  .cmp_hit_o, .tout_o, .tin_level_o);
